//--- verilog/line_ctrl_pkg.sv
/*
 * Shared constants for the per-channel line control register bank:
 * host addressing, bit positions, reset value and resistor codes.
 * Assumes an eight-channel transceiver with a byte-wide host port.
 */
package line_ctrl_pkg;

	localparam int        CH_COUNT      = 8;
	localparam int        CH_BITS       = 3;

	// host address: bit 7 zero, bits 6:4 channel, bits 3:0 register
	localparam logic [3:0] LINE_CTRL_REG = 4'h3;
	localparam int        CH_FIELD_LSB  = 4;

	localparam int        BIT_LINE_CODE = 5;
	localparam int        BIT_RES_HI    = 4;
	localparam int        BIT_RES_LO    = 3;
	localparam int        BIT_VIOLATION = 2;
	localparam int        BIT_PAT_ERROR = 1;
	localparam int        BIT_RATIO     = 0;

	localparam logic [7:0] WRITE_MASK    = 8'h3F;
	localparam logic [7:0] CTRL_RESET    = 8'h00;

	// external receive resistor in ohms, zero means none fitted
	localparam logic [7:0] OHMS_NONE     = 8'h00;
	localparam logic [7:0] OHMS_240      = 8'hF0;
	localparam logic [7:0] OHMS_210      = 8'hD2;
	localparam logic [7:0] OHMS_150      = 8'h96;

	function automatic logic [7:0] resistor_ohms(input logic [1:0] sel);
		case (sel)
			2'h0:    resistor_ohms = OHMS_NONE;
			2'h1:    resistor_ohms = OHMS_240;
			2'h2:    resistor_ohms = OHMS_210;
			default: resistor_ohms = OHMS_150;
		endcase
	endfunction : resistor_ohms

endpackage : line_ctrl_pkg

//--- verilog/channel_inject.sv
/*
 * One channel's injection edge logic: brings the two command bits and
 * the channel transmit clock into the master clock domain and emits a
 * single pulse per rising command transition, sampled at tx clock edges.
 * Assumes the tx clock is well below half the master clock rate.
 */
`timescale 1ns/1ps
module channel_inject (
	input  wire logic i_mclk,
	input  wire logic i_reset,
	input  wire logic i_tx_clock,
	input  wire logic i_violation_bit,
	input  wire logic i_error_bit,
	input  wire logic i_violation_allow,
	input  wire logic i_error_allow,
	output logic      o_violation_pulse,
	output logic      o_error_pulse
);

	logic [2:0] clk_sync_q;
	logic [1:0] viol_sync_q;
	logic [1:0] err_sync_q;
	logic       viol_seen_q;
	logic       err_seen_q;
	logic       tx_edge;

	// first stages feed only their second stages
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			clk_sync_q  <= 3'h0;
			viol_sync_q <= 2'h0;
			err_sync_q  <= 2'h0;
		end else begin
			clk_sync_q  <= {clk_sync_q[1:0], i_tx_clock};
			viol_sync_q <= {viol_sync_q[0], i_violation_bit};
			err_sync_q  <= {err_sync_q[0], i_error_bit};
		end
	end

	assign tx_edge = clk_sync_q[1] & ~clk_sync_q[2];

	// bits are looked at only on tx clock rising edges
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			viol_seen_q       <= 1'b0;
			err_seen_q        <= 1'b0;
			o_violation_pulse <= 1'b0;
			o_error_pulse     <= 1'b0;
		end else if (tx_edge) begin
			viol_seen_q       <= viol_sync_q[1];
			err_seen_q        <= err_sync_q[1];
			o_violation_pulse <= viol_sync_q[1] & ~viol_seen_q & i_violation_allow;
			o_error_pulse     <= err_sync_q[1] & ~err_seen_q & i_error_allow;
		end else begin
			o_violation_pulse <= 1'b0;
			o_error_pulse     <= 1'b0;
		end
	end

	a_pulse_on_edge: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_violation_pulse |-> $past(tx_edge))
		else $error("violation pulse without tx clock edge");

	a_error_on_edge: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_error_pulse |-> $past(tx_edge) && $past(err_sync_q[1]) && !$past(err_seen_q))
		else $error("error pulse without fresh rising command");

endmodule : channel_inject

//--- verilog/line_ctrl_bank.sv
/*
 * Eight copies of the channel line control register, reached through
 * the parallel host port, with decoded outputs and insertion pulses.
 * Assumes host strobes are one master clock cycle long and synchronous.
 */
// How it works
// - code bit 0 selects HDB3/B8ZS, 1 selects AMI coding.
// - code bit only acts in single-rail mode, otherwise ignored.
// - resistor bits: 00 none, 01 240, 10 210, 11 150 ohm.
// - rising violation bit inserts exactly one bipolar violation.
// - violation allowed into test pattern or single-rail user data.
// - both insert bits sampled at the channel tx clock rising edge.
// - rising error bit flips one test pattern bit while pattern enabled.
// - external termination: ratio bit 1 gives 1:2, 0 gives 1:2.45.
// - internal termination forces ratio 1:2 whatever the bit.
`timescale 1ns/1ps
module line_ctrl_bank (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_channel_tx_clock,
	input  wire logic [7:0]  i_single_rail,
	input  wire logic [7:0]  i_tx_test_pattern_enable,
	input  wire logic [7:0]  i_internal_term,
	output logic      [7:0]  o_rdata,
	output logic      [7:0]  o_ami_select,
	output logic      [15:0] o_rx_resistor_sel,
	output logic      [63:0] o_rx_resistor_ohms,
	output logic      [7:0]  o_ratio_one_two,
	output logic      [7:0]  o_violation_pulse,
	output logic      [7:0]  o_pattern_error_pulse
);

	logic [7:0] ctrl_q [line_ctrl_pkg::CH_COUNT];
	logic [2:0] chan;

	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr[7] == 1'b0) && (addr[3:0] == line_ctrl_pkg::LINE_CTRL_REG);
	endfunction : reg_hit

	assign chan = i_addr[line_ctrl_pkg::CH_FIELD_LSB +: line_ctrl_pkg::CH_BITS];

	// upper two bits belong to other logic and read back as zero
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			for (int i = 0; i < line_ctrl_pkg::CH_COUNT; i++) begin
				ctrl_q[i] <= line_ctrl_pkg::CTRL_RESET;
			end
		end else if (i_wr && reg_hit(i_addr)) begin
			ctrl_q[chan] <= i_wdata & line_ctrl_pkg::WRITE_MASK;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else if (i_rd && reg_hit(i_addr)) begin
			o_rdata <= ctrl_q[chan];
		end else if (i_rd) begin
			o_rdata <= 8'h00;
		end
	end

	genvar g;
	generate
		for (g = 0; g < line_ctrl_pkg::CH_COUNT; g++) begin : gen_ch
			logic [1:0] res_sel;

			assign res_sel = {ctrl_q[g][line_ctrl_pkg::BIT_RES_HI],
				ctrl_q[g][line_ctrl_pkg::BIT_RES_LO]};

			always_ff @(posedge i_mclk) begin
				if (i_reset) begin
					o_ami_select[g]              <= 1'b0;
					o_rx_resistor_sel[2*g +: 2]  <= 2'h0;
					o_rx_resistor_ohms[8*g +: 8] <= line_ctrl_pkg::OHMS_NONE;
					o_ratio_one_two[g]           <= 1'b1;
				end else begin
					// hdb3/b8zs when low; dual-rail coding is outside
					o_ami_select[g] <= i_single_rail[g] &
						ctrl_q[g][line_ctrl_pkg::BIT_LINE_CODE];
					o_rx_resistor_sel[2*g +: 2]  <= res_sel;
					o_rx_resistor_ohms[8*g +: 8] <= line_ctrl_pkg::resistor_ohms(res_sel);
					o_ratio_one_two[g] <= i_internal_term[g] |
						ctrl_q[g][line_ctrl_pkg::BIT_RATIO];
				end
			end

			// software must pulse 0 then 1; a lone 1 rewrite gives nothing
			channel_inject u_inject (
				.i_mclk            (i_mclk),
				.i_reset           (i_reset),
				.i_tx_clock        (i_channel_tx_clock[g]),
				.i_violation_bit   (ctrl_q[g][line_ctrl_pkg::BIT_VIOLATION]),
				.i_error_bit       (ctrl_q[g][line_ctrl_pkg::BIT_PAT_ERROR]),
				.i_violation_allow (i_tx_test_pattern_enable[g] | i_single_rail[g]),
				.i_error_allow     (i_tx_test_pattern_enable[g]),
				.o_violation_pulse (o_violation_pulse[g]),
				.o_error_pulse     (o_pattern_error_pulse[g])
			);
		end
	endgenerate

	a_ami_needs_rail: assert property (@(posedge i_mclk) disable iff (i_reset)
		!i_single_rail[0] |=> !o_ami_select[0])
		else $error("ami selected outside single-rail mode");

	a_ami_follows_bit: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_single_rail[0] |=> o_ami_select[0] == $past(ctrl_q[0][line_ctrl_pkg::BIT_LINE_CODE]))
		else $error("ami select does not follow code bit");

	a_res_240_ohm: assert property (@(posedge i_mclk) disable iff (i_reset)
		(ctrl_q[1][4:3] == 2'h1) |=> o_rx_resistor_ohms[15:8] == line_ctrl_pkg::OHMS_240)
		else $error("resistor code 01 not 240 ohm");

	a_res_150_ohm: assert property (@(posedge i_mclk) disable iff (i_reset)
		(ctrl_q[3][4:3] == 2'h3) |=> o_rx_resistor_ohms[31:24] == line_ctrl_pkg::OHMS_150)
		else $error("resistor code 11 not 150 ohm");

	a_ratio_external: assert property (@(posedge i_mclk) disable iff (i_reset)
		(!i_internal_term[0] && !ctrl_q[0][0]) |=> !o_ratio_one_two[0])
		else $error("external ratio 1:2.45 not selected");

	a_ratio_internal: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_internal_term[2] |=> o_ratio_one_two[2])
		else $error("internal termination not fixed at 1:2");

	a_write_stores: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_wr && i_addr == 8'h53) |=> ctrl_q[5] == ($past(i_wdata) & 8'h3F))
		else $error("channel 5 write not stored");

	a_reset_clears: assert property (@(posedge i_mclk)
		i_reset |=> ctrl_q[3] == line_ctrl_pkg::CTRL_RESET && o_violation_pulse == 8'h00)
		else $error("register not cleared by reset");

	a_single_violation: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_violation_pulse[0] |=> !o_violation_pulse[0] [*2])
		else $error("violation pulse longer than one cycle");

	a_violation_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_violation_pulse[1] |-> $past(i_single_rail[1] | i_tx_test_pattern_enable[1]))
		else $error("violation inserted with nowhere to go");

	a_error_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_pattern_error_pulse[0] |-> $past(i_tx_test_pattern_enable[0]))
		else $error("pattern error without pattern enabled");

	a_violation_synced: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_violation_pulse[0] |-> $past(ctrl_q[0][2], 3))
		else $error("violation pulse before bit was synchronised");

	// remaining resistor codes and the rx select copy
	a_res_none_code: assert property (@(posedge i_mclk) disable iff (i_reset)
		(ctrl_q[0][4:3] == 2'h0) |=> o_rx_resistor_ohms[7:0] == line_ctrl_pkg::OHMS_NONE)
		else $error("resistor code 00 not reported as none");

	a_res_210_ohm: assert property (@(posedge i_mclk) disable iff (i_reset)
		(ctrl_q[2][4:3] == 2'h2) |=> o_rx_resistor_ohms[23:16] == line_ctrl_pkg::OHMS_210)
		else $error("resistor code 10 not 210 ohm");

	a_res_sel_copy: assert property (@(posedge i_mclk) disable iff (i_reset)
		1'b1 |=> o_rx_resistor_sel[3:2] == $past(ctrl_q[1][4:3]))
		else $error("resistor select bits not copied");

	a_ami_off_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_single_rail[3] && !ctrl_q[3][line_ctrl_pkg::BIT_LINE_CODE]) |=> !o_ami_select[3])
		else $error("hdb3/b8zs channel shows ami");

	a_ratio_ext_bit: assert property (@(posedge i_mclk) disable iff (i_reset)
		(!i_internal_term[1] && ctrl_q[1][line_ctrl_pkg::BIT_RATIO]) |=> o_ratio_one_two[1])
		else $error("external ratio 1:2 not selected");

	// read path and write isolation
	a_read_channel: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_rd && reg_hit(i_addr)) |=> o_rdata == $past(ctrl_q[chan]))
		else $error("read data not the addressed channel");

	a_read_unmapped: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_rd && !reg_hit(i_addr)) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");

	a_rdata_upper_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_rdata[7:6] == 2'h0)
		else $error("reserved read bits not zero");

	a_rdata_holds: assert property (@(posedge i_mclk) disable iff (i_reset)
		!i_rd |=> $stable(o_rdata))
		else $error("read data changed without a read");

	a_write_miss: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_wr && !reg_hit(i_addr)) |=> $stable(ctrl_q[5]))
		else $error("unmapped write changed a register");

	a_write_isolate: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_wr && i_addr == 8'h53) |=> $stable(ctrl_q[4]))
		else $error("channel 5 write disturbed channel 4");

	a_reset_outputs: assert property (@(posedge i_mclk)
		i_reset |=> o_ratio_one_two == 8'hFF && o_ami_select == 8'h00 && o_rdata == 8'h00)
		else $error("decoded outputs not at reset values");

	// error path mirrors the violation checks
	a_single_error: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_pattern_error_pulse[0] |=> !o_pattern_error_pulse[0] [*2])
		else $error("pattern error pulse longer than one cycle");

	a_error_gate3: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_pattern_error_pulse[3] |-> $past(i_tx_test_pattern_enable[3]))
		else $error("pattern error on channel 3 without pattern");

	a_error_synced: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_pattern_error_pulse[0] |-> $past(ctrl_q[0][1], 3))
		else $error("error pulse before bit was synchronised");

	a_violation_gate0: assert property (@(posedge i_mclk) disable iff (i_reset)
		o_violation_pulse[0] |-> $past(i_single_rail[0] | i_tx_test_pattern_enable[0]))
		else $error("violation on channel 0 with nowhere to go");

	c_violation_seen: cover property (@(posedge i_mclk) o_violation_pulse[0]);
	c_error_seen: cover property (@(posedge i_mclk) o_pattern_error_pulse[0]);
	c_ami_active: cover property (@(posedge i_mclk) o_ami_select[0]);
	c_res_code3: cover property (@(posedge i_mclk) o_rx_resistor_sel[7:6] == 2'h3);
	c_read_hit: cover property (@(posedge i_mclk) i_rd && reg_hit(i_addr));

endmodule : line_ctrl_bank

//--- sim/line_ctrl_bank_test.sv
/*
 * Self-checking bench for line_ctrl_bank: host reads and writes, decoded
 * line outputs and insertion pulses on all eight channels.
 * Assumes single-cycle host strobes driven at the falling clock edge.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module line_ctrl_bank_test;
	logic        i_mclk                   = 1'h0;
	logic        i_reset                  = 1'h1;
	logic [7:0]  i_addr                   = 8'h00;
	logic [7:0]  i_wdata                  = 8'h00;
	logic        i_wr                     = 1'h0;
	logic        i_rd                     = 1'h0;
	logic [7:0]  i_channel_tx_clock       = 8'h55;
	logic [7:0]  i_single_rail            = 8'h00;
	logic [7:0]  i_tx_test_pattern_enable = 8'h00;
	logic [7:0]  i_internal_term          = 8'h00;
	wire  [7:0]  o_rdata;
	wire  [7:0]  o_ami_select;
	wire  [15:0] o_rx_resistor_sel;
	wire  [63:0] o_rx_resistor_ohms;
	wire  [7:0]  o_ratio_one_two;
	wire  [7:0]  o_violation_pulse;
	wire  [7:0]  o_pattern_error_pulse;
	int          err_total = 0;
	int          n_tests   = 0;
	int          seed      = 32'hd017;
	int          txdiv     = 0;
	int          vcnt[8];
	int          ecnt[8];
	logic [7:0]  exp_q[$];
	logic [7:0]  q_exp;
	logic [7:0]  ctrl[8];
	logic [7:0]  d;
	logic        rd_pend   = 1'h0;
	logic [7:0]  ohms_tab[4] = '{8'h00, 8'hF0, 8'hD2, 8'h96};

	line_ctrl_bank i_dut (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_channel_tx_clock(i_channel_tx_clock),
		.i_single_rail(i_single_rail), .i_tx_test_pattern_enable(i_tx_test_pattern_enable),
		.i_internal_term(i_internal_term), .o_rdata(o_rdata), .o_ami_select(o_ami_select),
		.o_rx_resistor_sel(o_rx_resistor_sel), .o_rx_resistor_ohms(o_rx_resistor_ohms),
		.o_ratio_one_two(o_ratio_one_two), .o_violation_pulse(o_violation_pulse),
		.o_pattern_error_pulse(o_pattern_error_pulse)
	);

	always #5 i_mclk = ~i_mclk;

	// tx clocks: 4 mclk high, 4 low, alternate channels in opposite phase
	always @(negedge i_mclk) begin
		txdiv <= (txdiv + 1) % 4;
		if (txdiv == 3) i_channel_tx_clock <= ~i_channel_tx_clock;
	end

	// read data lands one edge after the strobe; pulses counted per cycle high
	always @(posedge i_mclk) begin
		rd_pend <= i_rd;
		if (rd_pend) begin
			q_exp = exp_q.pop_front();
			`CHK(o_rdata, q_exp)
		end
		for (int c = 0; c < 8; c++) begin
			vcnt[c] += o_violation_pulse[c];
			ecnt[c] += o_pattern_error_pulse[c];
		end
	end

	// one assignment per strobe per falling edge, so calls chain back to back
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
		@(negedge i_mclk);
		i_wr = w;
		i_rd = r;
		i_addr = a;
		i_wdata = v;
	endtask : op

	task automatic idle(input int n);
		repeat (n) op(1'h0, 1'h0, 8'h00, 8'h00);
	endtask : idle

	task automatic wr(input int c, input logic [7:0] v);
		op(1'h1, 1'h0, 8'(c * 16 + 3), v);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		op(1'h0, 1'h1, a, 8'h00);
	endtask : rd

	task automatic read_all(input logic [7:0] m);
		for (int c = 0; c < 8; c++) rd(8'(c * 16 + 3), ctrl[c] & m);
		rd(8'h04, 8'h00);
		rd(8'h83, 8'h00);
		idle(2);
	endtask : read_all

	task automatic check_decode();
		for (int c = 0; c < 8; c++) begin
			`CHK(o_ami_select[c], i_single_rail[c] & ctrl[c][5])
			`CHK(o_rx_resistor_sel[2*c +: 2], ctrl[c][4:3])
			`CHK(o_rx_resistor_ohms[8*c +: 8], ohms_tab[ctrl[c][4:3]])
			`CHK(o_ratio_one_two[c], i_internal_term[c] | ctrl[c][0])
		end
	endtask : check_decode

	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	initial begin
		#200000;
		err_total++;
		summarize();
	end

	initial begin
		for (int c = 0; c < 8; c++) ctrl[c] = 8'h00;
		idle(16);
		i_reset = 1'h0;
		read_all(8'h00);
		// pinned bits make sure every gated path is reached, ch7 stays fully gated
		i_single_rail = (8'($random(seed)) | 8'h0B) & 8'h7F;
		i_internal_term = (8'($random(seed)) | 8'h04) & 8'hFC;
		i_tx_test_pattern_enable = (8'($random(seed)) | 8'h09) & 8'h7D;
		for (int c = 0; c < 8; c++) begin
			d = 8'($random(seed));
			ctrl[c] = {2'h0, d[5], 2'(c), 2'h0, d[0] | c[0]};
			wr(c, {d[7:6], ctrl[c][5:0]});
		end
		op(1'h1, 1'h0, 8'h84, 8'hFF);
		idle(3);
		check_decode();
		read_all(8'hFF);
		// set, set again (no new edge), clear, set: two insertions expected
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 8; c++) wr(c, ctrl[c] | ((k == 2) ? 8'h00 : 8'h06));
			idle(30);
		end
		for (int c = 0; c < 8; c++) begin
			`CHK(vcnt[c], (i_single_rail[c] | i_tx_test_pattern_enable[c]) ? 2 : 0)
			`CHK(ecnt[c], i_tx_test_pattern_enable[c] ? 2 : 0)
		end
		i_reset = 1'h1;
		idle(4);
		i_reset = 1'h0;
		for (int c = 0; c < 8; c++) ctrl[c] = 8'h00;
		read_all(8'hFF);
		check_decode();
		summarize();
	end
endmodule : line_ctrl_bank_test
